// >>> include/sbt_pkg.sv
// Shared constants and types of the serial bus arbiter timer.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
`default_nettype none
package sbt_pkg;
  // Bus shape
  localparam int unsigned ADR_W = 8;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned SEL_W = 4;
  // Register byte offsets
  localparam logic [ADR_W-1:0] ADR_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] ADR_DATA = 8'h04;
  localparam logic [ADR_W-1:0] ADR_CFG = 8'h08;
  // Field positions in the written word
  localparam int unsigned CTRL_MODE_HI_BIT = 7;
  localparam int unsigned CTRL_MODE_LO_BIT = 6;
  localparam int unsigned CTRL_ACLK_BIT = 4;
  localparam int unsigned CFG_SRC_BIT = 0;
  // Counter shape
  localparam int unsigned CNT_W = 9;
  // Arbitration sample points
  localparam logic [CNT_W-1:0] ARB_SAMPLE_BUS = 9'h038;
  localparam logic [CNT_W-1:0] ARB_SAMPLE_PRE = 9'h008;
  // Bus clock divided by four
  localparam logic [1:0] BUS_DIV_LAST = 2'h3;
  // Reset values
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic ACLK_RST = 1'b0;
  localparam logic CFG_SRC_RST = 1'b0;
  localparam logic TX_PIN_RST = 1'b1;
  localparam logic [DAT_W-1:0] DAT_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    SBT_MODE_IDLE = 2'b00,
    SBT_MODE_MEAS = 2'b01,
    SBT_MODE_ARB = 2'b10,
    SBT_MODE_RSVD = 2'b11
  } sbt_mode_t;

  // Read view of the control register, bit 7 first
  typedef struct packed {
    logic mode_hi;
    logic mode_lo;
    logic lost;
    logic aclk;
    logic fin;
    logic run;
    logic ovf;
    logic msb;
  } sbt_ctrl_t;

  // Wishbone classic request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DAT_W-1:0] dat;
  } sbt_wb_req_t;
endpackage : sbt_pkg
`default_nettype wire

// >>> rtl/sbt_arbiter_timer.sv
// Serial bus arbiter timer: 9-bit counter for bit time, break and bus arbitration.
// Assumes tx_data_i and osc_tick_i come from logic on core_clk_i; rxd_pin_i is a pin.
//
// Functional notes
// - Nine-bit counter with a separate overflow flag, steered by the control register.
// - Mode 00 idle and reset, 01 bit time measurement, 10 bus arbitration.
// - Both mode bits read and write; reset clears them to idle.
// - Lost flag read-only; cleared by writing zero to upper mode bit or reset.
// - Clock select set: half prescaler output; clear: bus clock divided by four.
// - Prescaler input is bus clock or oscillator ticks, chosen by a config bit.
// - Any control write clears the whole counter; finished and overflow flags clear unless set in the same cycle.
// - Running flag high exactly while the counter counts; reset clears it.
// - Overflow flag sets on counter overflow and stays until control write or reset.
// - In mode 00 the counter is held at zero and idle.
// - Counter MSB reads in control register; low eight bits in data register.
// - Measurement, select clear: start on receive falling edge, stop on next one.
// - Measurement, select clear: finished flag sets on the second falling edge.
// - Measurement, select set: start when receive low, stop on next rising edge.
// - Select set with receive already low at enable: counting begins at once.
// - Arbitration mode: counter restarts on each rising transmit data edge.
// - Arbitration: sample receive at count 38h or 08h; low sets lost flag.
// - While lost flag is set the transmit pin is forced high.
// - Transmit low before receive low resets counter; resume on next rising edge.
`default_nettype none
module sbt_arbiter_timer #(
  parameter int unsigned PRESC_DIV = 1
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Wishbone slave
  input wire sbt_pkg::sbt_wb_req_t wb_req_i,
  output logic [sbt_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial side
  input wire logic rxd_pin_i,
  input wire logic tx_data_i,
  input wire logic osc_tick_i,
  output logic tx_pin_o
);
  import sbt_pkg::*;

  localparam int unsigned PW = (PRESC_DIV > 1) ? $clog2(PRESC_DIV) : 1;

  generate
    if (PRESC_DIV < 1) begin : g_bad_div
      $error("PRESC_DIV must be at least one");
    end
  endgenerate

  // Counter increment with carry out
  function automatic logic [CNT_W:0] inc_cnt(input logic [CNT_W-1:0] v);
    inc_cnt = {1'b0, v} + 10'h001;
  endfunction

  logic ack_ff;
  logic [DAT_W-1:0] dat_ff;
  logic [1:0] mode_ff;
  logic aclk_ff;
  logic src_sel_ff;
  logic rx_meta_ff;
  logic rx_sync_ff;
  logic rx_prev_ff;
  logic tx_prev_ff;
  logic [1:0] bus_div_ff;
  logic [PW-1:0] presc_cnt_ff;
  logic presc_half_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic run_ff;
  logic fin_ff;
  logic ovf_ff;
  logic lost_ff;
  logic tx_pin_ff;

  sbt_mode_t mode;
  logic bus_req;
  logic wr_ctrl;
  logic wr_cfg;
  logic [DAT_W-1:0] nxt_dat;
  sbt_ctrl_t ctrl_view;
  logic rx_fall;
  logic rx_rise;
  logic tx_rise;
  logic tx_fall;
  logic bus_tick;
  logic src_tick;
  logic presc_tick;
  logic half_tick;
  logic cnt_tick;
  logic [CNT_W:0] cnt_inc;
  logic cnt_step;
  logic [CNT_W-1:0] samp_val;
  logic held_idle;
  logic sample_hit;
  logic lost_set;
  logic meas_start;
  logic meas_stop;
  logic arb_start;
  logic arb_abort;
  logic ovf_set;
  logic lost_clr;

  assign mode = sbt_mode_t'(mode_ff);

  // Bus slave: one wait state, write lands at the acknowledged edge
  assign bus_req = wb_req_i.cyc & wb_req_i.stb;
  assign wr_ctrl = bus_req & ack_ff & wb_req_i.we & (wb_req_i.adr == ADR_CTRL) & wb_req_i.sel[0];
  assign wr_cfg = bus_req & ack_ff & wb_req_i.we & (wb_req_i.adr == ADR_CFG) & wb_req_i.sel[0];

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
    end
  end

  always_comb begin
    ctrl_view.mode_hi = mode_ff[1];
    ctrl_view.mode_lo = mode_ff[0];
    ctrl_view.lost = lost_ff;
    ctrl_view.aclk = aclk_ff;
    ctrl_view.fin = fin_ff;
    ctrl_view.run = run_ff;
    ctrl_view.ovf = ovf_ff;
    ctrl_view.msb = cnt_ff[CNT_W-1];
    nxt_dat = DAT_RST;
    unique case (wb_req_i.adr)
      ADR_CTRL: nxt_dat[7:0] = ctrl_view;
      ADR_DATA: nxt_dat[7:0] = cnt_ff[7:0];
      ADR_CFG: nxt_dat[CFG_SRC_BIT] = src_sel_ff;
      default: nxt_dat = DAT_RST;
    endcase
  end

  // Unmapped reads answer zero
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dat_ff <= DAT_RST;
    end else if (bus_req & ~ack_ff) begin
      dat_ff <= nxt_dat;
    end
  end

  // Software controls
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_ff <= MODE_RST;
      aclk_ff <= ACLK_RST;
    end else if (wr_ctrl) begin
      mode_ff <= {wb_req_i.dat[CTRL_MODE_HI_BIT], wb_req_i.dat[CTRL_MODE_LO_BIT]};
      aclk_ff <= wb_req_i.dat[CTRL_ACLK_BIT];
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      src_sel_ff <= CFG_SRC_RST;
    end else if (wr_cfg) begin
      src_sel_ff <= wb_req_i.dat[CFG_SRC_BIT];
    end
  end

  // Receive pin synchroniser and edge history
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
      rx_prev_ff <= 1'b1;
      tx_prev_ff <= 1'b1;
    end else begin
      rx_meta_ff <= rxd_pin_i;
      rx_sync_ff <= rx_meta_ff;
      rx_prev_ff <= rx_sync_ff;
      tx_prev_ff <= tx_data_i;
    end
  end

  assign rx_fall = rx_prev_ff & ~rx_sync_ff;
  assign rx_rise = ~rx_prev_ff & rx_sync_ff;
  assign tx_rise = ~tx_prev_ff & tx_data_i;
  assign tx_fall = tx_prev_ff & ~tx_data_i;

  // Counter clock enables
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_div_ff <= 2'h0;
    end else begin
      bus_div_ff <= bus_div_ff + 2'h1;
    end
  end

  assign bus_tick = (bus_div_ff == BUS_DIV_LAST);
  assign src_tick = src_sel_ff ? osc_tick_i : 1'b1;
  assign presc_tick = src_tick & (presc_cnt_ff == PW'(PRESC_DIV - 1));

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      presc_cnt_ff <= '0;
      presc_half_ff <= 1'b0;
    end else if (src_tick) begin
      presc_cnt_ff <= presc_tick ? '0 : presc_cnt_ff + PW'(1);
      presc_half_ff <= presc_half_ff ^ presc_tick;
    end
  end

  assign half_tick = presc_tick & presc_half_ff;
  assign cnt_tick = aclk_ff ? half_tick : bus_tick;

  // Counter events
  assign cnt_inc = inc_cnt(cnt_ff);
  assign cnt_step = run_ff & cnt_tick;
  assign samp_val = aclk_ff ? ARB_SAMPLE_PRE : ARB_SAMPLE_BUS;
  assign held_idle = (mode == SBT_MODE_IDLE) | (mode == SBT_MODE_RSVD);
  assign sample_hit = (mode == SBT_MODE_ARB) & cnt_step & (cnt_inc[CNT_W-1:0] == samp_val);
  assign lost_set = sample_hit & ~rx_sync_ff;
  assign meas_start = (mode == SBT_MODE_MEAS) & ~run_ff & ~fin_ff &
                      (aclk_ff ? ~rx_sync_ff : rx_fall);
  assign meas_stop = (mode == SBT_MODE_MEAS) & run_ff & (aclk_ff ? rx_rise : rx_fall);
  assign arb_start = (mode == SBT_MODE_ARB) & tx_rise;
  assign arb_abort = (mode == SBT_MODE_ARB) & tx_fall & ~lost_ff;
  assign ovf_set = cnt_step & cnt_inc[CNT_W];
  assign lost_clr = wr_ctrl & ~wb_req_i.dat[CTRL_MODE_HI_BIT];

  // Count and run state; a control write wins over every start
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
    end else if (wr_ctrl | held_idle) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
    end else if (arb_start) begin
      cnt_ff <= '0;
      run_ff <= 1'b1;
    end else if (arb_abort) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
    end else if (meas_start) begin
      cnt_ff <= '0;
      run_ff <= 1'b1;
    end else if (meas_stop) begin
      run_ff <= 1'b0;
    end else if (sample_hit) begin
      // Count freezes at the sample point until a rising transmit edge, or a falling one while lost is clear
      cnt_ff <= cnt_inc[CNT_W-1:0];
      run_ff <= 1'b0;
    end else if (cnt_step) begin
      cnt_ff <= cnt_inc[CNT_W-1:0];
    end
  end

  // Sticky flags: a hardware set beats a clear in the same cycle
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fin_ff <= 1'b0;
      ovf_ff <= 1'b0;
    end else begin
      fin_ff <= meas_stop | (fin_ff & ~wr_ctrl);
      ovf_ff <= ovf_set | (ovf_ff & ~wr_ctrl);
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lost_ff <= 1'b0;
    end else begin
      lost_ff <= lost_set | (lost_ff & ~lost_clr);
    end
  end

  // One cycle late against tx_data_i, so the pin comes from a flop
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_pin_ff <= TX_PIN_RST;
    end else begin
      tx_pin_ff <= tx_data_i | lost_ff;
    end
  end

  assign wb_dat_o = dat_ff;
  assign wb_ack_o = ack_ff;
  assign tx_pin_o = tx_pin_ff;

  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_req_new;
    bus_req & ~ack_ff;
  endsequence

  sequence s_ack_pulse;
    ack_ff ##1 ~ack_ff;
  endsequence

  a_bus_ack_once: assert property (s_req_new |=> s_ack_pulse)
    else $error("ack not a single pulse one cycle after request");

  a_idle_holds_zero: assert property (held_idle ##1 held_idle |-> cnt_ff == '0 && !run_ff)
    else $error("counter not held in idle");

  a_write_clears_cnt: assert property (wr_ctrl && !meas_stop && !ovf_set |=>
                                       cnt_ff == '0 && !fin_ff && !ovf_ff)
    else $error("control write did not clear counter and flags");

  a_ovf_stays_set: assert property (ovf_ff && !wr_ctrl |=> ovf_ff)
    else $error("overflow flag dropped without a write");

  a_ovf_wraps_zero: assert property (ovf_set && !wr_ctrl && !held_idle && !arb_start && !arb_abort
                                     && !meas_stop && !sample_hit |=> cnt_ff == '0 && ovf_ff)
    else $error("counter did not wrap with overflow latched");

  a_meas_fin_edge: assert property ((mode == SBT_MODE_MEAS) && !aclk_ff && run_ff && rx_fall && !wr_ctrl
                                    |=> fin_ff && !run_ff)
    else $error("second falling edge did not finish measurement");

  a_break_starts: assert property ((mode == SBT_MODE_MEAS) && aclk_ff && !rx_sync_ff && !run_ff && !fin_ff
                                   && !wr_ctrl |=> run_ff)
    else $error("break measurement did not start on low receive");

  a_arb_restart: assert property (arb_start && !wr_ctrl |=> run_ff && cnt_ff == '0)
    else $error("transmit rise did not restart counter");

  a_lost_on_sample: assert property (lost_set |=> lost_ff ##1 tx_pin_ff)
    else $error("low sample did not set lost and force pin");

  a_lost_forces_tx: assert property (lost_ff |=> tx_pin_ff)
    else $error("transmit pin not forced high while lost");

  a_lost_clears: assert property (lost_clr && !lost_set |=> !lost_ff)
    else $error("lost flag not cleared by upper mode bit zero");

  a_abort_resets: assert property (arb_abort && !wr_ctrl && !arb_start |=> cnt_ff == '0 && !run_ff)
    else $error("early transmit low did not reset counter");

  sequence s_bus_gap;
    !bus_tick [*3] ##1 bus_tick;
  endsequence

  a_bus_tick_rate: assert property (bus_tick |=> s_bus_gap)
    else $error("bus clock tick not every fourth clock");

  a_presc_half_rate: assert property (presc_tick |=> presc_half_ff != $past(presc_half_ff))
    else $error("half rate phase did not toggle on prescaler tick");

  a_osc_source: assert property (src_sel_ff && !osc_tick_i |-> !presc_tick)
    else $error("prescaler ticked without an oscillator tick");

  a_count_steps: assert property (cnt_step && (mode == SBT_MODE_MEAS) && !wr_ctrl && !meas_stop
                                  |=> cnt_ff == $past(cnt_ff) + 9'h001)
    else $error("counter did not advance by one on a tick");

  a_stopped_holds: assert property (!run_ff && !wr_ctrl && !held_idle && !arb_start && !arb_abort
                                    && !meas_start |=> $stable(cnt_ff))
    else $error("counter moved while stopped");

  a_meas_holds_count: assert property ((mode == SBT_MODE_MEAS) && fin_ff && !run_ff && !wr_ctrl
                                       |=> $stable(cnt_ff))
    else $error("finished measurement did not hold its count");

  a_fin_needs_stop: assert property ($rose(fin_ff) |-> $past(meas_stop))
    else $error("finished flag set without a measurement stop");

  a_break_stops: assert property ((mode == SBT_MODE_MEAS) && aclk_ff && run_ff && rx_rise && !wr_ctrl
                                  |=> fin_ff && !run_ff)
    else $error("receive rise did not end break measurement");

  a_ovf_needs_wrap: assert property ($rose(ovf_ff) |-> $past(cnt_ff) == 9'h1ff)
    else $error("overflow flag set without a wrap from all ones");

  a_sample_stops: assert property (sample_hit && !wr_ctrl && !arb_start && !arb_abort
                                   |=> !run_ff && cnt_ff == $past(samp_val))
    else $error("counter did not stop at the sample point");

  a_lost_needs_low: assert property ($rose(lost_ff) |-> $past(sample_hit) && !$past(rx_sync_ff))
    else $error("lost flag set without a low sample");

  a_tx_follows: assert property (!lost_ff |=> tx_pin_ff == $past(tx_data_i))
    else $error("transmit pin did not follow transmit data");

endmodule : sbt_arbiter_timer
`default_nettype wire

// >>> verification/sbt_bus_node.sv
// Model of another node on the shared single-wire serial bus.
// Assumes an open-drain line with pull-up; the bench commands when this node drives dominant.
`default_nettype none
module sbt_bus_node (
  // Our transmit pin and the dominant command
  input wire logic tx_pin_i,
  input wire logic dominant_i,
  // Line level seen at our receive pin
  output logic rxd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Wired-and with pull-up, so a released line reads high and never stale
  assign rxd_o = tx_pin_i & ~dominant_i;
endmodule // sbt_bus_node
`default_nettype wire

// >>> verification/sbt_arbiter_timer_tb_top.sv
// Self-checking bench of the serial bus arbiter timer with a reference model of its flags.
// Assumes one 25 MHz clock; another bus node pulls the shared line low on command.
`default_nettype none
module sbt_arbiter_timer_tb_top;
  import sbt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PD = 2;
  logic core_clk_i, arst_n_i, tx_d, osc_tick, dom, rxd, tx_pin, ack, meas_on;
  sbt_wb_req_t req;
  logic [31:0] rd_dat, rd;
  int errors, checks_done, a;
  int npulse = 0;
  int seed = 32'h044a_2f30;
  logic [1:0] m_mode;
  logic m_aclk, m_lost, m_fin, m_run, m_ovf;

  sbt_arbiter_timer #(.PRESC_DIV(PD)) DUT (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .wb_req_i(req),
    .wb_dat_o(rd_dat), .wb_ack_o(ack), .rxd_pin_i(rxd), .tx_data_i(tx_d), .osc_tick_i(osc_tick),
    .tx_pin_o(tx_pin));
  sbt_bus_node node (.tx_pin_i(tx_pin), .dominant_i(dom), .rxd_o(rxd));

  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  // Random oscillator ticks; counted while a break is measured
  always @(posedge core_clk_i) begin
    if (meas_on && osc_tick) npulse <= npulse + 1;
    osc_tick <= 1'($random(seed));
  end

  function automatic logic [31:0] ctrl_exp();
    return 32'({m_mode, m_lost, m_aclk, m_fin, m_run, m_ovf, 1'b0});
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
    checks_done++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t count %h outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  // Ack checked mid-cycle, taken at the following rising edge
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    req <= {2'b11, we, adr, 4'h1, wd};
    @(negedge core_clk_i);
    while (ack !== 1'b1 && n < 100) begin
      @(negedge core_clk_i);
      n++;
    end
    if (n == 100) begin
      errors++;
      $display("[FAIL] %0t no acknowledge", $time);
    end
    @(posedge core_clk_i);
    rd = rd_dat;
    req <= '0;
    @(posedge core_clk_i);
  endtask
  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h0000_0000);
    chk(rd, exp);
  endtask
  task automatic wr_ctrl(input logic [7:0] v);
    wb_xfer(1'b1, ADR_CTRL, 32'(v));
    m_mode = v[7:6];
    m_aclk = v[4];
    if (!v[7]) m_lost = 1'b0;
    {m_fin, m_run, m_ovf} = 3'h0;
  endtask
  task automatic pulse(input int n);
    dom <= 1'b1;
    tick(n);
    dom <= 1'b0;
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    errors = 0;
    checks_done = 0;
    req = '0;
    {tx_d, dom, meas_on, arst_n_i} = 4'h8;
    {m_mode, m_aclk, m_lost, m_fin, m_run, m_ovf} = '0;
    tick(8);
    arst_n_i <= 1'b1;
    tick(1);
    rd_chk(ADR_CTRL, ctrl_exp());
    rd_chk(ADR_DATA, 32'h0000_0000);
    chk(32'(tx_pin), 32'h0000_0001);
    for (a = 0; a < 3; a++) begin
      wr_ctrl(8'(a << 6));
      rd_chk(ADR_CTRL, ctrl_exp());
    end
    rd_chk(8'h0c, 32'h0000_0000);
    // Baud recovery: falls 100 clocks apart
    wr_ctrl(8'h40);
    pulse(10);
    tick(90);
    pulse(10);
    m_fin = 1'b1;
    tick(5);
    rd_chk(ADR_CTRL, ctrl_exp());
    wb_xfer(1'b0, ADR_DATA, 32'h0000_0000);
    chk_rng(rd, 24, 26);
    wb_xfer(1'b1, ADR_CFG, 32'h0000_0001);
    rd_chk(ADR_CFG, 32'h0000_0001);
    // Break already present when enabled
    dom <= 1'b1;
    tick(5);
    wr_ctrl(8'h50);
    meas_on <= 1'b1;
    m_run = 1'b1;
    rd_chk(ADR_CTRL, ctrl_exp());
    tick(200);
    dom <= 1'b0;
    meas_on <= 1'b0;
    {m_run, m_fin} = 2'b01;
    tick(10);
    rd_chk(ADR_CTRL, ctrl_exp());
    wb_xfer(1'b0, ADR_DATA, 32'h0000_0000);
    chk_rng(rd, npulse / (2 * PD) - 2, npulse / (2 * PD) + 2);
    // Run past 1FFh
    wb_xfer(1'b1, ADR_CFG, 32'h0000_0000);
    wr_ctrl(8'h40);
    pulse(10);
    tick(1200);
    m_run = 1'b1;
    rd_chk(ADR_CTRL, ctrl_exp() | 32'h0000_0001);
    tick(900);
    m_ovf = 1'b1;
    rd_chk(ADR_CTRL, ctrl_exp());
    wb_xfer(1'b0, ADR_DATA, 32'h0000_0000);
    chk_rng(rd, 10, 24);
    wr_ctrl(8'h00);
    pulse(10);
    tick(20);
    rd_chk(ADR_CTRL, ctrl_exp());
    rd_chk(ADR_DATA, 32'h0000_0000);
    // Arbitration lost at both sample points
    for (a = 0; a < 2; a++) begin
      tx_d <= 1'b0;
      wr_ctrl(8'h80 | 8'(a << 4));
      tx_d <= 1'b1;
      dom <= 1'b1;
      tick(a ? 62 : 254);
      tx_d <= 1'b0;
      m_lost = 1'b1;
      tick(2);
      chk(32'(tx_pin), 32'h0000_0001);
      rd_chk(ADR_CTRL, ctrl_exp());
      wb_xfer(1'b1, ADR_DATA, 32'h0000_00ff);
      rd_chk(ADR_DATA, a ? 32'h0000_0008 : 32'h0000_0038);
      wr_ctrl(8'h80 | 8'(a << 4));
      rd_chk(ADR_CTRL, ctrl_exp());
      dom <= 1'b0;
      wr_ctrl(8'(a << 4));
      rd_chk(ADR_CTRL, ctrl_exp());
      chk(32'(tx_pin), 32'h0000_0000);
    end
    // Early transmit low, then a clean win
    wr_ctrl(8'h80);
    tx_d <= 1'b1;
    tick(40);
    tx_d <= 1'b0;
    tick(5);
    rd_chk(ADR_DATA, 32'h0000_0000);
    tx_d <= 1'b1;
    tick(254);
    rd_chk(ADR_CTRL, ctrl_exp());
    rd_chk(ADR_DATA, 32'h0000_0038);
    end_of_test();
  end

  initial begin
    tick(20000);
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end
endmodule // sbt_arbiter_timer_tb_top
`default_nettype wire
